// file: hw/csrs_top.sv
// clock source selection and reset sequencing with apb registers
`timescale 1ns/1ps

module csrs_top
	import csrs_pkg::*;
#(
	parameter int POWER_UP_DELAY_TIMER_TICKS = CSRS_POWER_UP_DELAY_TIMER_TICKS,
	parameter int OST_EDGES = CSRS_OST_EDGES,
	parameter int FILTER_CYC = CSRS_PIN_FILTER_CYC
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// reset sources, sleep state and wake request
	input wire logic por_pulse,
	input wire logic brownout_reset,
	input wire logic reset_pin_n,
	input wire logic watchdog_timeout,
	input wire logic core_sleeping,
	input wire logic wake_request,
	// timing sources
	input wire logic power_up_delay_timer_rc_tick,
	input wire logic slow_osc_tick,
	input wire logic crystal_in_pin,
	// general purpose drive for the crystal out pin
	input wire logic gpio_drive_data,
	input wire logic gpio_drive_en,
	// crystal out pin
	output logic crystal_out_pin_o,
	output logic crystal_out_pin_oe_n,
	output logic crystal_out_is_gpio,
	output logic crystal_amp_en,
	// core side
	output logic core_reset,
	output logic core_stall,
	output logic reset_power_up,
	output logic wake_resume,
	output logic osc_run,
	output logic slow_clock_active
);

	// every piece of state in one record
	typedef struct packed {
		logic [CSRS_CFG_W-1:0] cfg; // mode, pin enable, delay enable
		logic fast_sel; // fast clock select
		logic [31:0] rdata; // read data captured in setup
		logic [3:0] filt_cnt; // pin stability counter
		logic pin_filt; // filtered pin level
		logic xin_prev; // last crystal input sample
		csrs_tm_e tm; // delay chain state
		logic ost_wake; // start-up count is for a wake
		logic [15:0] tcnt; // delay chain counter
		logic pu; // last reset was power-up kind
		logic last_pin; // last reset from pin
		logic last_wdt; // last reset from watchdog
		logic wake; // one-cycle resume pulse
		logic rst; // core reset
		logic slow; // slow speed in effect
		logic stalling; // speed change stall
		logic [11:0] scnt; // stall counter
		logic [1:0] div; // divide by four counter
		logic divided_clock_output; // divided clock
		logic pin_o; // crystal out pin data
		logic pin_oe_n; // crystal out pin enable
	} csrs_state_s;

	localparam csrs_state_s CSRS_ST_RST = '{
		cfg: CSRS_CFG_RST,
		fast_sel: CSRS_FAST_RST,
		rdata: 32'h0000_0000,
		filt_cnt: 4'h0,
		pin_filt: 1'b1,
		xin_prev: 1'b0,
		tm: TM_HOLD,
		ost_wake: 1'b0,
		tcnt: 16'h0000,
		pu: 1'b1,
		last_pin: 1'b0,
		last_wdt: 1'b0,
		wake: 1'b0,
		rst: 1'b1,
		slow: 1'b0,
		stalling: 1'b0,
		scnt: 12'h000,
		div: 2'h0,
		divided_clock_output: 1'b0,
		pin_o: 1'b0,
		pin_oe_n: 1'b1
	};

	csrs_state_s s_q; // registered state
	csrs_state_s s_d; // next state

	csrs_mode_e mode; // selected clock source
	logic is_xtal; // one of the three crystal modes
	logic is_rc; // internal or resistor rc
	logic is_divided_clock_output; // rc mode with clock out
	logic pin_rst; // filtered, enabled pin reset
	logic wdt_rst; // watchdog reset while running
	logic wake_ev; // wake from sleep
	logic xin_rise; // crystal input rising edge
	logic setup_ph; // apb setup phase
	logic wr_acc; // apb write access
	logic mapped; // address decodes
	logic [31:0] stat; // status word

	// mode decode
	always_comb
	begin
		mode = csrs_mode_e'(s_q.cfg[CSRS_CFG_MODE_LSB +: 3]);
		is_xtal = (mode == LOW_POWER_CRYSTAL_MODE) || (mode == STANDARD_CRYSTAL_MODE)
			|| (mode == HIGH_SPEED_CRYSTAL_MODE);
		is_rc = mode[2];
		is_divided_clock_output = mode[2] & mode[0];
	end

	// status word and apb decode
	always_comb
	begin
		stat = 32'h0000_0000;
		stat[CSRS_STAT_RESET_BIT] = s_q.rst;
		stat[CSRS_STAT_PU_BIT] = s_q.pu;
		stat[CSRS_STAT_PIN_BIT] = s_q.last_pin;
		stat[CSRS_STAT_WDT_BIT] = s_q.last_wdt;
		stat[CSRS_STAT_WAKE_BIT] = s_q.ost_wake;
		stat[CSRS_STAT_TM_LSB +: 4] = s_q.tm;
		stat[CSRS_STAT_STALL_BIT] = s_q.stalling;
		stat[CSRS_STAT_SLOW_BIT] = s_q.slow;
		setup_ph = psel & ~penable;
		wr_acc = psel & penable & pwrite & ce;
		mapped = (paddr == CSRS_CFG_OFS) || (paddr == CSRS_PCTL_OFS) || (paddr == CSRS_STAT_OFS);
	end

	// source conditioning
	always_comb
	begin
		// pin only counts when enabled, else tied inactive
		pin_rst = s_q.cfg[CSRS_CFG_PIN_EN_BIT] & ~s_q.pin_filt;
		// watchdog while awake resets, while asleep wakes
		wdt_rst = watchdog_timeout & ~core_sleeping;
		wake_ev = core_sleeping & (watchdog_timeout | wake_request);
		xin_rise = crystal_in_pin & ~s_q.xin_prev;
	end

	// next state
	always_comb
	begin
		s_d = s_q;
		s_d.wake = 1'b0;
		s_d.xin_prev = crystal_in_pin;

		// read data captured in setup so prdata comes from a flop
		if (setup_ph)
		begin
			unique case (paddr)
				CSRS_CFG_OFS: s_d.rdata = {27'h000_0000, s_q.cfg};
				CSRS_PCTL_OFS: s_d.rdata = {31'h0000_0000, s_q.fast_sel};
				CSRS_STAT_OFS: s_d.rdata = stat;
				default: s_d.rdata = 32'h0000_0000;
			endcase
		end

		// register writes, only the low lane holds fields
		if (wr_acc && pstrb[0])
		begin
			if (paddr == CSRS_CFG_OFS)
				s_d.cfg = pwdata[CSRS_CFG_W-1:0];
			else if (paddr == CSRS_PCTL_OFS)
				s_d.fast_sel = pwdata[CSRS_PCTL_FAST_BIT];
		end

		// pin level must hold steady before it is believed
		if (reset_pin_n == s_q.pin_filt)
			s_d.filt_cnt = 4'h0;
		else if (s_q.filt_cnt == 4'(FILTER_CYC - 1))
		begin
			s_d.pin_filt = reset_pin_n;
			s_d.filt_cnt = 4'h0;
		end
		else
			s_d.filt_cnt = s_q.filt_cnt + 4'h1;

		// delay chain
		unique case (s_q.tm)
			TM_HOLD:
			begin
				// brownout over: delay always applied
				s_d.tcnt = 16'h0000;
				if (!brownout_reset)
					s_d.tm = TM_POWER_UP_DELAY_TIMER;
			end
			TM_POWER_UP_DELAY_TIMER:
			begin
				// counted on the timer's own rc ticks
				if (power_up_delay_timer_rc_tick)
				begin
					if (s_q.tcnt == 16'(POWER_UP_DELAY_TIMER_TICKS - 1))
					begin
						s_d.tcnt = 16'h0000;
						s_d.tm = is_xtal ? TM_OST : TM_RUN;
					end
					else
						s_d.tcnt = s_q.tcnt + 16'h0001;
				end
			end
			TM_OST:
			begin
				// crystal input edges
				if (xin_rise)
				begin
					if (s_q.tcnt == 16'(OST_EDGES - 1))
					begin
						s_d.tcnt = 16'h0000;
						s_d.tm = TM_RUN;
						s_d.wake = s_q.ost_wake;
						s_d.ost_wake = 1'b0;
					end
					else
						s_d.tcnt = s_q.tcnt + 16'h0001;
				end
			end
			TM_RUN:
			begin
				// wake resumes; crystal modes first restart count
				if (wake_ev)
				begin
					if (is_xtal)
					begin
						s_d.tm = TM_OST;
						s_d.ost_wake = 1'b1;
						s_d.tcnt = 16'h0000;
					end
					else
						s_d.wake = 1'b1;
				end
			end
			default:
			begin
				// illegal code: restart the chain
				s_d.tm = TM_HOLD;
				s_d.tcnt = 16'h0000;
			end
		endcase

		// reset sources override the chain
		if (brownout_reset)
		begin
			// held and reinitialised until supply recovers
			s_d.tm = TM_HOLD;
			s_d.tcnt = 16'h0000;
			s_d.ost_wake = 1'b0;
			s_d.pu = 1'b1;
			s_d.last_pin = 1'b0;
			s_d.last_wdt = 1'b0;
		end
		else if (por_pulse)
		begin
			// delay starts with the pulse, if enabled
			if (s_q.cfg[CSRS_CFG_POWER_UP_DELAY_TIMER_EN_BIT])
				s_d.tm = TM_POWER_UP_DELAY_TIMER;
			else
				s_d.tm = is_xtal ? TM_OST : TM_RUN;
			s_d.tcnt = 16'h0000;
			s_d.ost_wake = 1'b0;
			s_d.pu = 1'b1;
			s_d.last_pin = 1'b0;
			s_d.last_wdt = 1'b0;
		end
		else if (pin_rst || wdt_rst)
		begin
			// no delays; a running power-up chain continues
			if (s_q.ost_wake)
			begin
				s_d.tm = TM_RUN;
				s_d.ost_wake = 1'b0;
				s_d.tcnt = 16'h0000;
			end
			if (s_q.tm == TM_RUN)
				s_d.pu = 1'b0;
			s_d.last_pin = pin_rst;
			s_d.last_wdt = wdt_rst;
			s_d.wake = 1'b0;
		end

		// core reset: every source gone and every stage done
		s_d.rst = brownout_reset | por_pulse | pin_rst | wdt_rst
			| (s_d.tm == TM_HOLD) | (s_d.tm == TM_POWER_UP_DELAY_TIMER)
			| ((s_d.tm == TM_OST) & ~s_d.ost_wake);

		// dual speed in rc modes only
		if (s_d.rst || !is_rc)
		begin
			s_d.slow = 1'b0;
			s_d.stalling = 1'b0;
			s_d.scnt = 12'h000;
			if (s_d.rst)
				s_d.fast_sel = CSRS_FAST_RST;
		end
		else if (s_q.stalling)
		begin
			// core stalled while the oscillator retunes
			if (s_q.scnt == 12'h000)
			begin
				s_d.stalling = 1'b0;
				s_d.slow = ~s_q.slow;
			end
			else
				s_d.scnt = s_q.scnt - 12'h001;
		end
		else if (s_q.fast_sel == s_q.slow)
		begin
			s_d.stalling = 1'b1;
			if (s_q.slow)
				s_d.scnt = 12'(CSRS_TO_FAST_CYC - 1);
			else
				s_d.scnt = 12'(CSRS_TO_SLOW_CYC - 1);
		end

		// divided clock, slow rate follows its fixed own tick
		if (s_d.rst || !is_rc)
		begin
			s_d.div = 2'h0;
			s_d.divided_clock_output = 1'b0;
		end
		else if (!s_q.slow || slow_osc_tick)
		begin
			s_d.div = s_q.div + 2'h1;
			s_d.divided_clock_output = s_d.div[1];
		end

		// crystal out pin function
		if (is_xtal)
		begin
			// pin belongs to the crystal amplifier
			s_d.pin_o = 1'b0;
			s_d.pin_oe_n = 1'b1;
		end
		else if (is_divided_clock_output)
		begin
			s_d.pin_o = s_d.divided_clock_output;
			s_d.pin_oe_n = 1'b0;
		end
		else
		begin
			// external clock or rc without clock out
			s_d.pin_o = gpio_drive_data;
			s_d.pin_oe_n = ~gpio_drive_en;
		end
	end

	// state register, frozen while ce is low
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			s_q <= CSRS_ST_RST;
		else if (ce)
			s_q <= s_d;
	end

	// outputs
	always_comb
	begin
		prdata = s_q.rdata;
		pready = ce;
		pslverr = psel & penable & ~mapped;
		crystal_out_pin_o = s_q.pin_o;
		crystal_out_pin_oe_n = s_q.pin_oe_n;
		crystal_out_is_gpio = ~is_xtal & ~is_divided_clock_output;
		crystal_amp_en = is_xtal;
		core_reset = s_q.rst;
		core_stall = s_q.stalling | ((s_q.tm == TM_OST) & s_q.ost_wake);
		// register file: undefined registers read as zero and raise pslverr
		reset_power_up = s_q.rst & s_q.pu;
		wake_resume = s_q.wake;
		osc_run = is_rc & ~s_q.rst;
		slow_clock_active = s_q.slow;
	end

endmodule

// file: hw/csrs_pkg.sv
// constants, modes and sequencer states for the clock source and reset sequencer
package csrs_pkg;

	// apb register byte offsets
	localparam logic [7:0] CSRS_CFG_OFS = 8'h00;
	localparam logic [7:0] CSRS_PCTL_OFS = 8'h04;
	localparam logic [7:0] CSRS_STAT_OFS = 8'h08;

	// configuration register fields
	localparam int CSRS_CFG_MODE_LSB = 0;
	localparam int CSRS_CFG_PIN_EN_BIT = 3;
	localparam int CSRS_CFG_POWER_UP_DELAY_TIMER_EN_BIT = 4;
	localparam int CSRS_CFG_W = 5;
	// internal rc, reset pin enabled, power-up delay enabled
	localparam logic [4:0] CSRS_CFG_RST = 5'h1c;

	// power control register fields
	localparam int CSRS_PCTL_FAST_BIT = 0;
	localparam logic CSRS_FAST_RST = 1'b1;

	// status register fields
	localparam int CSRS_STAT_RESET_BIT = 0;
	localparam int CSRS_STAT_PU_BIT = 1;
	localparam int CSRS_STAT_PIN_BIT = 2;
	localparam int CSRS_STAT_WDT_BIT = 3;
	localparam int CSRS_STAT_WAKE_BIT = 4;
	localparam int CSRS_STAT_TM_LSB = 5;
	localparam int CSRS_STAT_STALL_BIT = 9;
	localparam int CSRS_STAT_SLOW_BIT = 10;

	// clock period and timing figures
	localparam int CSRS_PCLK_NS = 40;
	localparam int CSRS_TO_SLOW_MIN_NS = 100000;
	localparam int CSRS_TO_FAST_MIN_NS = 1250;
	localparam int CSRS_PIN_FILTER_NS = 200;
	localparam int CSRS_TO_SLOW_CYC = (CSRS_TO_SLOW_MIN_NS + CSRS_PCLK_NS - 1) / CSRS_PCLK_NS;
	localparam int CSRS_TO_FAST_CYC = (CSRS_TO_FAST_MIN_NS + CSRS_PCLK_NS - 1) / CSRS_PCLK_NS;
	localparam int CSRS_PIN_FILTER_CYC = (CSRS_PIN_FILTER_NS + CSRS_PCLK_NS - 1) / CSRS_PCLK_NS;
	localparam int CSRS_OST_EDGES = 1024;
	localparam int CSRS_POWER_UP_DELAY_TIMER_TICKS = 1024;

	// clock source select encodings
	typedef enum logic [2:0] {
		LOW_POWER_CRYSTAL_MODE = 3'h0,
		STANDARD_CRYSTAL_MODE = 3'h1,
		HIGH_SPEED_CRYSTAL_MODE = 3'h2,
		EXTERNAL_CLOCK_MODE = 3'h3,
		INTERNAL_RC_MODE = 3'h4,
		INTERNAL_RC_DIVIDED_CLOCK_OUTPUT_MODE = 3'h5,
		RESISTOR_SET_RC_MODE = 3'h6,
		RESISTOR_SET_RC_DIVIDED_CLOCK_OUTPUT_MODE = 3'h7
	} csrs_mode_e;

	// delay chain states, one-hot
	typedef enum logic [3:0] {
		TM_HOLD = 4'h1,
		TM_POWER_UP_DELAY_TIMER = 4'h2,
		TM_OST = 4'h4,
		TM_RUN = 4'h8
	} csrs_tm_e;

endpackage

// file: test/csrs_checker.sv
// port assertions for the clock source and reset sequencer
`timescale 1ns/1ps
module csrs_checker
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic por_pulse,
	input wire logic brownout_reset,
	input wire logic watchdog_timeout,
	input wire logic core_sleeping,
	input wire logic crystal_out_pin_o,
	input wire logic crystal_out_is_gpio,
	input wire logic crystal_amp_en,
	input wire logic core_reset,
	input wire logic core_stall,
	input wire logic reset_power_up,
	input wire logic osc_run,
	input wire logic slow_clock_active
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	int stall_len; // length of the latest stall run
	logic stall_q; // stall seen last cycle
	// measure each stall run, held after it ends
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			stall_len <= 0;
			stall_q <= 1'b0;
		end
		else
		begin
			stall_q <= core_stall;
			if (core_stall)
				stall_len <= stall_q ? stall_len + 1 : 1;
		end
	end
	// power-on pulse has ended
	sequence s_por;
		por_pulse ##1 !por_pulse;
	endsequence
	// watchdog fires while asleep
	sequence s_sleep_wdt;
		core_sleeping && watchdog_timeout && !core_reset;
	endsequence
	property p_osc_stop;
		core_reset |-> !osc_run;
	endproperty
	a_osc_stop: assert property (p_osc_stop) else $error("rc oscillator runs in reset");
	property p_clk_low;
		core_reset && $past(core_reset) && !crystal_out_is_gpio && !crystal_amp_en |-> !crystal_out_pin_o;
	endproperty
	a_clk_low: assert property (p_clk_low) else $error("divided clock high in reset");
	property p_free_pin;
		crystal_out_is_gpio |-> !crystal_amp_en;
	endproperty
	a_free_pin: assert property (p_free_pin) else $error("gpio pin with amplifier on");
	property p_to_slow;
		$rose(slow_clock_active) && !core_reset |-> stall_len >= 2500 && stall_len <= 7501;
	endproperty
	a_to_slow: assert property (p_to_slow) else $error("fast to slow stall length");
	property p_to_fast;
		$fell(slow_clock_active) && !core_reset |-> stall_len >= 32 && stall_len <= 82;
	endproperty
	a_to_fast: assert property (p_to_fast) else $error("slow to fast stall length");
	property p_por_hold;
		s_por |=> core_reset [*8];
	endproperty
	a_por_hold: assert property (p_por_hold) else $error("core left reset after power-on");
	property p_bo_kind;
		brownout_reset |=> core_reset && reset_power_up;
	endproperty
	a_bo_kind: assert property (p_bo_kind) else $error("brownout not a power-up reset");
	property p_wdt_wake;
		s_sleep_wdt |=> !core_reset [*4];
	endproperty
	a_wdt_wake: assert property (p_wdt_wake) else $error("watchdog wake caused a reset");
endmodule
bind csrs_top csrs_checker u_chk(.pclk, .presetn, .por_pulse, .brownout_reset, .watchdog_timeout, .core_sleeping,
	.crystal_out_pin_o, .crystal_out_is_gpio, .crystal_amp_en, .core_reset, .core_stall, .reset_power_up, .osc_run,
	.slow_clock_active);

// file: test/csrs_far_model.sv
// far side: crystal on the input pin and the reset pin circuit
`timescale 1ns/1ps
module csrs_far_model
(
	input wire logic pclk,
	input wire logic crystal_amp_en,
	input wire logic pin_low,
	output logic crystal_in_pin,
	output logic reset_pin_n
);
	logic [1:0] ph_q = 2'h0; // crystal phase
	// oscillates at a quarter of pclk only while the amplifier runs
	always_ff @(posedge pclk)
		ph_q <= crystal_amp_en ? ph_q + 2'h1 : 2'h0;
	assign crystal_in_pin = ph_q[1];
	// pull-up on the pin, switch pulls it low
	assign reset_pin_n = !pin_low;
endmodule

// file: test/csrs_top_tb.sv
// self-checking bench for the clock source and reset sequencer
`timescale 1ns/1ps
module csrs_top_tb;
	import csrs_pkg::*;
	typedef struct packed {logic [2:0] m; logic g; logic a; logic o;} csrs_row_s;
	logic pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0, er;
	logic [7:0] paddr = 8'h00, tk = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic por_pulse = 0, brownout_reset = 0, watchdog_timeout = 0, core_sleeping = 0, wake_request = 0;
	logic power_up_delay_timer_rc_tick = 0, slow_osc_tick = 0, gpio_drive_data = 0, gpio_drive_en = 0, pin_low = 0;
	logic pready, pslverr, crystal_in_pin, reset_pin_n, crystal_out_pin_o, crystal_out_pin_oe_n, osc_run;
	logic crystal_out_is_gpio, crystal_amp_en, core_reset, core_stall, reset_power_up, wake_resume, slow_clock_active;
	int n_mismatch = 0, cmp_count = 0, i, t;
	// per mode: gpio pin, amplifier, rc oscillator
	csrs_row_s rows [8] = '{'{3'h0, 1'b0, 1'b1, 1'b0}, '{3'h1, 1'b0, 1'b1, 1'b0}, '{3'h2, 1'b0, 1'b1, 1'b0},
		'{3'h3, 1'b1, 1'b0, 1'b0}, '{3'h4, 1'b1, 1'b0, 1'b1}, '{3'h5, 1'b0, 1'b0, 1'b1},
		'{3'h6, 1'b1, 1'b0, 1'b1}, '{3'h7, 1'b0, 1'b0, 1'b1}};
	always #20 pclk = ~pclk;
	// free-running power-up timer and slow oscillator ticks
	always @(posedge pclk)
	begin
		tk <= tk + 8'h01;
		power_up_delay_timer_rc_tick <= tk[2:0] == 3'h0;
		slow_osc_tick <= tk[3:0] == 4'h0;
	end
	csrs_top #(.POWER_UP_DELAY_TIMER_TICKS(4), .OST_EDGES(8), .FILTER_CYC(5)) dut(.pclk, .presetn, .ce, .psel, .penable, .pwrite,
		.paddr, .pwdata, .pstrb(4'hf), .prdata, .pready, .pslverr, .por_pulse, .brownout_reset, .reset_pin_n,
		.watchdog_timeout, .core_sleeping, .wake_request, .power_up_delay_timer_rc_tick, .slow_osc_tick, .crystal_in_pin,
		.gpio_drive_data, .gpio_drive_en, .crystal_out_pin_o, .crystal_out_pin_oe_n, .crystal_out_is_gpio,
		.crystal_amp_en, .core_reset, .core_stall, .reset_power_up, .wake_resume, .osc_run, .slow_clock_active);
	csrs_far_model far(.pclk, .crystal_amp_en, .pin_low, .crystal_in_pin, .reset_pin_n);
	// verdict and stop
	task end_sim;
		$display("compares %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// compare one value
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask
	// one apb transfer, result in rd and er
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do
		begin
			@(posedge pclk);
			k++;
		end
		while (pready !== 1'b1 && k < 50);
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge pclk);
		if (k >= 50)
		begin
			n_mismatch++;
			end_sim();
		end
	endtask
	// bounded wait on reset, slow flag or wake
	task wt(input int s, input logic v, input int lim);
		t = 0;
		do
		begin
			@(posedge pclk);
			t++;
		end
		while ((s == 0 ? core_reset : s == 1 ? slow_clock_active : wake_resume) !== v && t < lim);
		if (t >= lim)
		begin
			n_mismatch++;
			end_sim();
		end
	endtask
	// reset pin low for n cycles
	task pulse(input int n);
		pin_low <= 1;
		repeat (n) @(posedge pclk);
		pin_low <= 0;
	endtask
	// main sequence
	initial
	begin
		repeat (8) @(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
		chk("hold", 1, core_reset);
		wt(0, 0, 200);
		chk("power_up_delay_timer", 1, t >= 24);
		apb(0, CSRS_CFG_OFS, 32'h0);
		chk("cfg", 32'h0000_001c, rd);
		apb(0, CSRS_PCTL_OFS, 32'h0);
		chk("pctl", 32'h0000_0001, rd);
		apb(1, 8'h0c, 32'h0000_00ff);
		chk("unmapped", 1, er);
		apb(0, 8'h0c, 32'h0);
		chk("unmapped", 0, rd);
		for (i = 0; i < 8; i++)
		begin
			apb(1, CSRS_CFG_OFS, {29'h0000_0003, rows[i].m});
			apb(0, CSRS_CFG_OFS, 32'h0);
			chk("mode", {29'h0000_0003, rows[i].m}, rd);
			chk("gpio", rows[i].g, crystal_out_is_gpio);
			chk("amp", rows[i].a, crystal_amp_en);
			chk("osc", rows[i].o, osc_run);
		end
		apb(1, CSRS_CFG_OFS, 32'h0000_001b);
		gpio_drive_en <= 1;
		repeat (3) @(posedge pclk);
		chk("oe", 0, crystal_out_pin_oe_n);
		gpio_drive_en <= 0;
		repeat (3) @(posedge pclk);
		chk("oe", 1, crystal_out_pin_oe_n);
		apb(1, CSRS_CFG_OFS, 32'h0000_001d);
		t = 0;
		er = crystal_out_pin_o;
		repeat (40)
		begin
			@(posedge pclk);
			t += (crystal_out_pin_o && !er);
			er = crystal_out_pin_o;
		end
		chk("divided_clock_output", 10, t);
		chk("oe", 0, crystal_out_pin_oe_n);
		apb(1, CSRS_PCTL_OFS, 32'h0);
		wt(1, 1, 9000);
		chk("to_slow", 1, t >= 2497 && t <= 7501);
		apb(1, CSRS_PCTL_OFS, 32'h0000_0001);
		wt(1, 0, 200);
		chk("to_fast", 1, t >= 30 && t <= 82);
		pulse(3);
		repeat (6) @(posedge pclk);
		chk("glitch", 0, core_reset);
		pulse(8);
		chk("pin", 1, core_reset);
		chk("pin_kind", 0, reset_power_up);
		wt(0, 0, 100);
		apb(1, CSRS_CFG_OFS, 32'h0000_0015);
		pulse(8);
		chk("pin_off", 0, core_reset);
		watchdog_timeout <= 1;
		@(posedge pclk);
		watchdog_timeout <= 0;
		@(posedge pclk);
		chk("wdt", 1, core_reset);
		chk("wdt_pin", 1, reset_pin_n);
		chk("wdt_kind", 0, reset_power_up);
		wt(0, 0, 100);
		core_sleeping <= 1;
		watchdog_timeout <= 1;
		@(posedge pclk);
		watchdog_timeout <= 0;
		wt(2, 1, 50);
		chk("wake", 0, core_reset);
		core_sleeping <= 0;
		apb(1, CSRS_CFG_OFS, 32'h0000_0009);
		brownout_reset <= 1;
		repeat (3) @(posedge pclk);
		chk("bo_kind", 1, reset_power_up);
		brownout_reset <= 0;
		wt(0, 0, 300);
		chk("bo_delay", 1, t >= 52);
		por_pulse <= 1;
		@(posedge pclk);
		por_pulse <= 0;
		repeat (2) @(posedge pclk);
		wt(0, 0, 300);
		chk("por_delay", 1, t >= 24 && t <= 45);
		fork
			apb(0, CSRS_STAT_OFS, 32'h0);
			begin
				@(posedge pclk);
				ce <= 0;
				repeat (3) @(posedge pclk);
				ce <= 1;
			end
		join
		chk("state", 4'h8, rd[8:5]);
		end_sim();
	end
endmodule
